// ### verilog/asc_map.svh
// Register offsets, field positions, reset values and timing values
`ifndef ASC_MAP_SVH
`define ASC_MAP_SVH

// ----------------------------------------------------------------
// Register offsets (word index on the 3-bit address port)
// ----------------------------------------------------------------
`define ASC_OFF_MODE 3'h0
`define ASC_OFF_CHAN 3'h1
`define ASC_OFF_RESULT 3'h2
`define ASC_OFF_STATUS 3'h3
`define ASC_OFF_MASK 3'h4
`define ASC_OFF_INFO 3'h5

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ASC_MODE_EN_BIT 0
`define ASC_MODE_SPD_LO 1
`define ASC_MODE_SPD_HI 2
`define ASC_MODE_START_BIT 7
`define ASC_ST_DONE_BIT 0
`define ASC_ST_SUSPECT_BIT 1
`define ASC_INFO_WARM_BIT 0
`define ASC_INFO_BUSY_BIT 1

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define ASC_MODE_RST 8'h00
`define ASC_CHAN_RST 2'h0
`define ASC_MASK_RST 2'h0

// ----------------------------------------------------------------
// Timing, in nanoseconds, plus the sampling divider; cycle counts are derived in the module
// ----------------------------------------------------------------
`define ASC_CLK_NS 100
`define ASC_WARM_NS 14000
`define ASC_START_DLY_NS 300
`define ASC_CONV0_NS 12000
`define ASC_CONV1_NS 18000
`define ASC_CONV2_NS 24000
`define ASC_CONV3_NS 36000
`define ASC_SAMPLE_DIV 6

`endif

// ### verilog/asc_pkg.sv
// Types shared by the converter sequencing control
`default_nettype none
package asc_pkg;

  // Sequencer phases
  typedef enum logic [1:0] {
    ASC_IDLE = 2'b00,
    ASC_DELAY = 2'b01,
    ASC_SAMPLE = 2'b10,
    ASC_CONVERT = 2'b11
  } asc_state_t;

  // Interrupt status layout: done and suspect-first-result
  typedef logic [1:0] asc_irq_t;

endpackage
`default_nettype wire

// ### verilog/asc_sar_core.sv
// Successive-approximation bit trial register
`timescale 1ns/1ps
`default_nettype none

module asc_sar_core #(
  parameter int BITS = 10
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic abort_i,
  input wire logic start_i,
  input wire logic step_i,
  input wire logic comp_i,
  output logic [BITS-1:0] code_o,
  output logic [BITS-1:0] result_o,
  output logic done_o
);

  // ----------------------------------------------------------------
  // Trial state
  // ----------------------------------------------------------------
  logic [BITS-1:0] mask_q; // One-hot bit under trial
  logic [BITS-1:0] trial_d; // Code after judging the current bit

  // Comparator high means input above trial level: keep the bit
  always_comb begin
    trial_d = comp_i ? code_o : (code_o & ~mask_q);
  end

  // Trial code and bit pointer
  always_ff @(posedge sys_clk_i) begin
    if (rst_i || abort_i) begin
      code_o <= '0;
      mask_q <= '0;
    end else if (start_i) begin
      // Begin at mid scale
      code_o <= {1'b1, {(BITS-1){1'b0}}};
      mask_q <= {1'b1, {(BITS-1){1'b0}}};
    end else if (step_i && (mask_q != '0)) begin
      // Keep or drop this bit, then try the next lower one
      code_o <= trial_d | (mask_q >> 1);
      mask_q <= mask_q >> 1;
    end
  end

  // Finished word and its one-cycle done pulse
  always_ff @(posedge sys_clk_i) begin
    if (rst_i || abort_i) begin
      result_o <= '0;
      done_o <= 1'b0;
    end else begin
      done_o <= step_i && mask_q[0];
      if (step_i && mask_q[0]) begin
        result_o <= trial_d;
      end
    end
  end

endmodule
`default_nettype wire

// ### verilog/asc_seq_ctrl.sv
// Sequencing, timing and register control around the SAR converter
`timescale 1ns/1ps
`default_nettype none
`include "asc_map.svh"

module asc_seq_ctrl
  import asc_pkg::*;
#(
  parameter int BITS = 10,
  parameter int DW = 16
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [2:0] addr_i,
  input wire logic [DW-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [DW-1:0] rdata_o,
  input wire logic comp_i,
  output logic comp_en_o,
  output logic sample_o,
  output logic [BITS-1:0] dac_code_o,
  output logic [1:0] chan_o,
  output logic conversion_end_irq_o,
  output logic irq_o
);

  // ----------------------------------------------------------------
  // Timing counts derived from the clock period
  // ----------------------------------------------------------------
  // Least times round up
  localparam int WARM_CYC = (`ASC_WARM_NS + `ASC_CLK_NS - 1) / `ASC_CLK_NS;
  localparam int DLY_CYC = (`ASC_START_DLY_NS + `ASC_CLK_NS - 1) / `ASC_CLK_NS;
  localparam int CONV0_CYC = `ASC_CONV0_NS / `ASC_CLK_NS;
  localparam int CONV1_CYC = `ASC_CONV1_NS / `ASC_CLK_NS;
  localparam int CONV2_CYC = `ASC_CONV2_NS / `ASC_CLK_NS;
  localparam int CONV3_CYC = `ASC_CONV3_NS / `ASC_CLK_NS;
  localparam int CW = 9; // Phase counter width, holds the longest conversion
  localparam int WW = $clog2(WARM_CYC + 1);

  // ----------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------
  // Total conversion time in cycles for a speed setting
  function automatic logic [CW-1:0] conv_cyc(input logic [1:0] spd);
    case (spd)
      2'h0: conv_cyc = CW'(CONV0_CYC);
      2'h1: conv_cyc = CW'(CONV1_CYC);
      2'h2: conv_cyc = CW'(CONV2_CYC);
      default: conv_cyc = CW'(CONV3_CYC);
    endcase
  endfunction

  // Sampling window is a sixth of the whole conversion
  function automatic logic [CW-1:0] samp_cyc(input logic [1:0] spd);
    samp_cyc = conv_cyc(spd) / CW'(`ASC_SAMPLE_DIV);
  endfunction

  // Each bit trial shares the remaining time evenly
  function automatic logic [CW-1:0] bit_cyc(input logic [1:0] spd);
    bit_cyc = (conv_cyc(spd) - samp_cyc(spd)) / CW'(BITS);
  endfunction

  // ----------------------------------------------------------------
  // Registers and internal signals
  // ----------------------------------------------------------------
  logic [7:0] mode_q; // Converter mode register
  logic [1:0] chan_q; // Channel select register
  logic [BITS-1:0] result_q; // Conversion result register
  asc_irq_t status_q; // Sticky interrupt status
  asc_irq_t mask_q; // Interrupt mask
  asc_state_t state_q; // Sequencer phase
  asc_state_t state_d;
  logic [CW-1:0] cnt_q; // Phase counter
  logic [CW-1:0] cnt_d;
  logic [WW-1:0] warm_q; // Comparator settling counter
  logic suspect_q; // Next result was started too early
  logic start_prev_q; // Start bit one cycle ago

  logic enable_bit; // comparator_enable_bit
  logic start_bit; // conversion_start_bit
  logic [1:0] speed;
  logic warm;
  logic wr_mode;
  logic wr_chan;
  logic wr_cfg;
  logic abort;
  logic core_start;
  logic core_step;
  logic core_done;
  logic [BITS-1:0] core_code;
  logic [BITS-1:0] core_result;
  logic post;
  asc_irq_t events;

  assign enable_bit = mode_q[`ASC_MODE_EN_BIT];
  assign start_bit = mode_q[`ASC_MODE_START_BIT];
  assign speed = mode_q[`ASC_MODE_SPD_HI:`ASC_MODE_SPD_LO];
  assign warm = (warm_q == WW'(WARM_CYC));
  assign wr_mode = wr_i && (addr_i == `ASC_OFF_MODE);
  assign wr_chan = wr_i && (addr_i == `ASC_OFF_CHAN);
  assign wr_cfg = wr_mode || wr_chan;
  // Any config write aborts the sequence; with the start bit set it restarts from the start delay
  assign abort = wr_cfg || !start_bit;

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  // Mode register
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      mode_q <= `ASC_MODE_RST;
    end else if (wr_mode) begin
      mode_q <= wdata_i[7:0];
    end
  end

  // Channel select register; inputs first..last are codes 0..3
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      chan_q <= `ASC_CHAN_RST;
    end else if (wr_chan) begin
      chan_q <= wdata_i[1:0];
    end
  end

  // Interrupt mask register
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      mask_q <= `ASC_MASK_RST;
    end else if (wr_i && (addr_i == `ASC_OFF_MASK)) begin
      mask_q <= wdata_i[1:0];
    end
  end

  // ----------------------------------------------------------------
  // Comparator settling and early-start detection
  // ----------------------------------------------------------------
  // Counts up while enabled; dropping the enable restarts settling
  always_ff @(posedge sys_clk_i) begin
    if (rst_i || !enable_bit) begin
      warm_q <= '0;
    end else if (!warm) begin
      warm_q <= warm_q + WW'(1);
    end
  end

  // A start raised before settling ends taints the first result
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      start_prev_q <= 1'b0;
      suspect_q <= 1'b0;
    end else begin
      start_prev_q <= start_bit;
      if (start_bit && !start_prev_q && (!enable_bit || !warm)) begin
        suspect_q <= 1'b1;
      end else if (post) begin
        suspect_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Phase decode feeding the bit trial register
  assign core_start = (state_q == ASC_SAMPLE) && (cnt_q == '0) && !abort;
  assign core_step = (state_q == ASC_CONVERT) && (cnt_q == '0) && !abort;

  // Next phase and counter
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    if (abort) begin
      state_d = ASC_IDLE;
      cnt_d = '0;
    end else begin
      case (state_q)
        ASC_IDLE: begin
          // Launch waits out the start delay first
          state_d = ASC_DELAY;
          cnt_d = CW'(DLY_CYC - 1);
        end
        ASC_DELAY: begin
          if (cnt_q == '0) begin
            state_d = ASC_SAMPLE;
            cnt_d = samp_cyc(speed) - CW'(1);
          end else begin
            cnt_d = cnt_q - CW'(1);
          end
        end
        ASC_SAMPLE: begin
          if (cnt_q == '0) begin
            state_d = ASC_CONVERT;
            cnt_d = bit_cyc(speed) - CW'(1);
          end else begin
            cnt_d = cnt_q - CW'(1);
          end
        end
        ASC_CONVERT: begin
          if (core_done) begin
            // Back-to-back repeat on the same channel
            state_d = ASC_SAMPLE;
            cnt_d = samp_cyc(speed) - CW'(1);
          end else if (cnt_q == '0) begin
            cnt_d = bit_cyc(speed) - CW'(1);
          end else begin
            cnt_d = cnt_q - CW'(1);
          end
        end
        default: begin
          state_d = ASC_IDLE;
          cnt_d = '0;
        end
      endcase
    end
  end

  // Phase registers
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      state_q <= ASC_IDLE;
      cnt_q <= '0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end

  // ----------------------------------------------------------------
  // Bit trial register
  // ----------------------------------------------------------------
  asc_sar_core #(
    .BITS(BITS)
  ) u_core (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .abort_i(abort),
    .start_i(core_start),
    .step_i(core_step),
    .comp_i(comp_i),
    .code_o(core_code),
    .result_o(core_result),
    .done_o(core_done)
  );

  // ----------------------------------------------------------------
  // Result posting
  // ----------------------------------------------------------------
  // A finished word posts unless a config write lands in the same cycle
  assign post = core_done && !wr_cfg;

  // Result register: a word finished one cycle before a channel
  // rewrite still posts, and the rewrite then zeroes it
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      result_q <= '0;
    end else if (wr_cfg) begin
      // Contents are not meaningful after reconfiguring; zero is chosen
      result_q <= '0;
    end else if (post) begin
      result_q <= core_result;
    end
  end

  // Events: completion, and completion of a tainted first word
  assign events = {post && suspect_q, post};

  // Sticky status, write one to clear; a new event beats the clear.
  // A channel write alone never touches it.
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      status_q <= '0;
    end else if (wr_i && (addr_i == `ASC_OFF_STATUS)) begin
      status_q <= (status_q & ~wdata_i[1:0]) | events;
    end else begin
      status_q <= status_q | events;
    end
  end

  // ----------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------
  // Data is taken from the old register value, so a read in the cycle
  // of posting sees the prior word and the new one lands after it
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rdata_o <= '0;
    end else if (rd_i) begin
      case (addr_i)
        `ASC_OFF_MODE: rdata_o <= DW'(mode_q);
        `ASC_OFF_CHAN: rdata_o <= DW'(chan_q);
        `ASC_OFF_RESULT: rdata_o <= DW'(result_q);
        `ASC_OFF_STATUS: rdata_o <= DW'(status_q);
        `ASC_OFF_MASK: rdata_o <= DW'(mask_q);
        `ASC_OFF_INFO: rdata_o <= DW'({state_q != ASC_IDLE, warm});
        default: rdata_o <= '0; // Unmapped reads zero
      endcase
    end else begin
      rdata_o <= '0;
    end
  end

  // ----------------------------------------------------------------
  // Outputs toward the analog side and the processor
  // ----------------------------------------------------------------
  // Analog controls, registered for glitch-free switching
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      comp_en_o <= 1'b0;
      sample_o <= 1'b0;
      dac_code_o <= '0;
      chan_o <= '0;
    end else begin
      comp_en_o <= enable_bit;
      sample_o <= (state_d == ASC_SAMPLE);
      dac_code_o <= core_code;
      chan_o <= chan_q;
    end
  end

  // Interrupt lines: a one-cycle completion pulse and a masked level
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      conversion_end_irq_o <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      conversion_end_irq_o <= post;
      irq_o <= |(status_q & mask_q);
    end
  end

endmodule
`default_nettype wire

// ### tb/asc_seq_ctrl_properties.sv
// Port-level checker for the converter sequencing control
`timescale 1ns/1ps
`default_nettype none
`include "asc_map.svh"
module asc_seq_ctrl_properties #(
  parameter int BITS = 10,
  parameter int DW = 16
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [2:0] addr_i,
  input wire logic [DW-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [DW-1:0] rdata_o,
  input wire logic comp_i,
  input wire logic comp_en_o,
  input wire logic sample_o,
  input wire logic [BITS-1:0] dac_code_o,
  input wire logic [1:0] chan_o,
  input wire logic conversion_end_irq_o,
  input wire logic irq_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  // ------------------------------------------------------------
  // Shadow copies of the software settings
  // ------------------------------------------------------------
  logic mode_w; // Mode register write
  logic cfg_w; // Any write that aborts a conversion
  logic [1:0] spd_q, chan_q, mask_q;
  logic en_q; // Enable bit as last written
  logic ok_q; // Sampling phase not cut short by a config write
  logic [7:0] cnt_q; // Cycles of the current sampling phase
  logic [7:0] s_len; // Expected sampling length for the speed
  assign mode_w = wr_i && addr_i == `ASC_OFF_MODE;
  assign cfg_w = mode_w || (wr_i && addr_i == `ASC_OFF_CHAN);
  // Sampling length is one sixth of the conversion time per speed
  always_comb begin
    case (spd_q)
      2'h0: s_len = 8'h14;
      2'h1: s_len = 8'h1e;
      2'h2: s_len = 8'h28;
      default: s_len = 8'h3c;
    endcase
  end
  // Track writes; an aborted phase must not be judged on its length
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      spd_q <= 2'h0;
      chan_q <= 2'h0;
      mask_q <= 2'h0;
      en_q <= 1'b0;
      ok_q <= 1'b0;
      cnt_q <= 8'h00;
    end else begin
      if (mode_w) begin
        spd_q <= wdata_i[2:1];
        en_q <= wdata_i[0];
      end
      if (wr_i && addr_i == `ASC_OFF_CHAN) begin
        chan_q <= wdata_i[1:0];
      end
      if (wr_i && addr_i == `ASC_OFF_MASK) begin
        mask_q <= wdata_i[1:0];
      end
      ok_q <= !cfg_w && (!sample_o || ok_q);
      cnt_q <= sample_o ? cnt_q + 8'h01 : 8'h00;
    end
  end
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  AST_RDATA_IDLE: assert property (!$past(rd_i) |-> rdata_o == '0)
    else $error("read data not zero outside the read slot");
  AST_END_PULSE: assert property (conversion_end_irq_o |=> !conversion_end_irq_o)
    else $error("conversion end pulse longer than one cycle");
  AST_SAMPLE_LEN: assert property ($fell(sample_o) && ok_q |-> cnt_q == s_len)
    else $error("sampling phase length wrong for speed");
  AST_START_DELAY: assert property (mode_w && wdata_i[`ASC_MODE_START_BIT]
    |=> (!sample_o)[*3] ##[1:3] sample_o)
    else $error("sampling not preceded by the start delay");
  AST_IRQ_MASKED: assert property ($past(mask_q) == 2'h0 |-> !irq_o)
    else $error("interrupt raised while fully masked");
  AST_IRQ_RAISE: assert property (conversion_end_irq_o && mask_q[0] |-> ##[0:1] irq_o)
    else $error("unmasked completion did not raise interrupt");
  AST_CHAN_OUT: assert property (chan_q == $past(chan_q) |-> chan_o == chan_q)
    else $error("channel output differs from written channel");
  AST_EN_OUT: assert property (en_q == $past(en_q) |-> comp_en_o == en_q)
    else $error("comparator enable differs from mode bit");
  AST_CFG_QUIET: assert property (cfg_w |=> (!conversion_end_irq_o)[*8])
    else $error("completion posted after a config write");
  AST_STOP_IDLE: assert property (mode_w && !wdata_i[`ASC_MODE_START_BIT]
    |=> ##1 (!sample_o)[*8])
    else $error("sampling continued after stop");
  // Main scenarios reached
  cover property (conversion_end_irq_o && irq_o);
  cover property ($fell(sample_o) && ok_q && spd_q == 2'h3);
  cover property (cfg_w && sample_o);
endmodule
bind asc_seq_ctrl asc_seq_ctrl_properties #(.BITS(BITS), .DW(DW)) u_asc_seq_ctrl_properties (
  .sys_clk_i(sys_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
  .rd_i(rd_i), .rdata_o(rdata_o), .comp_i(comp_i), .comp_en_o(comp_en_o),
  .sample_o(sample_o), .dac_code_o(dac_code_o), .chan_o(chan_o),
  .conversion_end_irq_o(conversion_end_irq_o), .irq_o(irq_o));
`default_nettype wire

// ### tb/asc_seq_ctrl_tb_top.sv
// Self-checking bench for the converter sequencing control
`timescale 1ns/1ps
`default_nettype none
`include "asc_map.svh"
module asc_seq_ctrl_tb_top;
  typedef struct packed {
    logic [2:0] a;
    logic [15:0] d;
    logic [15:0] e;
  } asc_row_t;
  logic sys_clk_i, rst_i, wr_i, rd_i, comp_i;
  logic [2:0] addr_i;
  logic [15:0] wdata_i, rdata_o;
  logic comp_en_o, sample_o, conversion_end_irq_o, irq_o;
  logic [9:0] dac_code_o, target;
  logic [1:0] chan_o;
  int fail_count = 0;
  int n_checks = 0;
  int n;
  // Sampling lengths for speeds 0..3
  logic [15:0] slen [4] = '{16'h14, 16'h1e, 16'h28, 16'h3c};
  // Write then read back: written value, expected read
  asc_row_t rows [8] = '{
    '{3'h1, 16'hffff, 16'h0003}, '{3'h4, 16'h00ff, 16'h0003},
    '{3'h4, 16'h0000, 16'h0000}, '{3'h0, 16'h0006, 16'h0006},
    '{3'h0, 16'h0000, 16'h0000}, '{3'h6, 16'hffff, 16'h0000},
    '{3'h2, 16'hffff, 16'h0000}, '{3'h5, 16'hffff, 16'h0000}};
  asc_seq_ctrl u_asc_seq_ctrl (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .comp_i(comp_i), .comp_en_o(comp_en_o),
    .sample_o(sample_o), .dac_code_o(dac_code_o), .chan_o(chan_o),
    .conversion_end_irq_o(conversion_end_irq_o), .irq_o(irq_o));
  // ------------------------------------------------------------
  // Clock, analog side and shared tasks
  // ------------------------------------------------------------
  initial begin
    sys_clk_i = 1'b0;
    forever #50 sys_clk_i = ~sys_clk_i;
  end
  // Comparator keeps a trial bit while the input is at or above it
  always @(posedge sys_clk_i) comp_i <= target >= dac_code_o;
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Write strobe lasts one cycle; the next task waits for a fresh edge
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge sys_clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [2:0] a, input logic [15:0] e, input string what);
    @(posedge sys_clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    @(negedge sys_clk_i);
    chk(what, e, rdata_o);
  endtask
  // Bounded wait for the one-cycle completion pulse
  task automatic wait_end(input int lim);
    int k = 0;
    @(negedge sys_clk_i);
    while (conversion_end_irq_o !== 1'b1 && k < lim) begin
      @(negedge sys_clk_i);
      k++;
    end
    chk("end pulse", 16'h1, {15'h0, k < lim});
  endtask
  task automatic test_done;
    if (fail_count == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Whole run is near 2000 cycles; five times that means a hang
  initial begin
    repeat (10000) @(posedge sys_clk_i);
    fail_count++;
    test_done();
  end
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    rst_i = 1'b1;
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = 3'h0;
    wdata_i = 16'h0;
    target = 10'h2a5;
    repeat (8) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    for (int a = 0; a < 8; a++) begin
      rd_chk(3'(a), 16'h0, "reset value");
    end
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd_chk(rows[i].a, rows[i].e, "register");
    end
    // Warm up past 14 us, then one conversion per speed
    wr(`ASC_OFF_MASK, 16'h1);
    wr(`ASC_OFF_MODE, 16'h1);
    repeat (150) @(posedge sys_clk_i);
    rd_chk(`ASC_OFF_INFO, 16'h1, "warm info");
    for (int s = 0; s < 4; s++) begin
      wr(`ASC_OFF_MODE, 16'h1);
      wr(`ASC_OFF_MODE, 16'h81 | 16'(s << 1));
      wait (sample_o === 1'b1);
      n = 0;
      @(negedge sys_clk_i);
      while (sample_o === 1'b1) begin
        n++;
        @(negedge sys_clk_i);
      end
      chk("sample length", slen[s], 16'(n));
      wait_end(400);
      rd_chk(`ASC_OFF_RESULT, {6'h0, target}, "result");
    end
    rd_chk(`ASC_OFF_STATUS, 16'h1, "status warm");
    chk("irq unmasked", 16'h1, {15'h0, irq_o});
    // Stop zeroes the result; a channel write keeps the done flag
    wr(`ASC_OFF_MODE, 16'h1);
    rd_chk(`ASC_OFF_RESULT, 16'h0, "result after config");
    wr(`ASC_OFF_CHAN, 16'h2);
    rd_chk(`ASC_OFF_STATUS, 16'h1, "done after chan");
    chk("chan out", 16'h2, {14'h0, chan_o});
    wr(`ASC_OFF_MASK, 16'h2);
    repeat (2) @(negedge sys_clk_i);
    chk("irq masked", 16'h0, {15'h0, irq_o});
    // Disabled start, then start right after enable: both suspect
    for (int i = 0; i < 2; i++) begin
      wr(`ASC_OFF_MODE, 16'h0);
      wr(`ASC_OFF_STATUS, 16'h3);
      rd_chk(`ASC_OFF_STATUS, 16'h0, "status cleared");
      if (i == 1) begin
        wr(`ASC_OFF_MODE, 16'h1);
      end
      wr(`ASC_OFF_MODE, 16'h80 | 16'(i));
      wait_end(200);
      rd_chk(`ASC_OFF_STATUS, 16'h3, "suspect status");
      chk("irq suspect", 16'h1, {15'h0, irq_o});
    end
    // Speed 0 repeats every 121 cycles; land a read, then a channel
    // write, on the very edge at which a finished word posts
    wait_end(200);
    target = 10'h15a;
    repeat (119) @(posedge sys_clk_i);
    rd_chk(`ASC_OFF_RESULT, 16'h02a5, "read on post");
    rd_chk(`ASC_OFF_RESULT, 16'h015a, "result after read");
    wait_end(200);
    wr(`ASC_OFF_STATUS, 16'h3);
    repeat (117) @(posedge sys_clk_i);
    wr(`ASC_OFF_CHAN, 16'h2);
    @(negedge sys_clk_i);
    chk("end pulse on config", 16'h0, {15'h0, conversion_end_irq_o});
    rd_chk(`ASC_OFF_STATUS, 16'h0, "status on config");
    rd_chk(`ASC_OFF_RESULT, 16'h0, "result on config");
    // Second reset in mid-sampling
    wr(`ASC_OFF_MODE, 16'h81);
    repeat (10) @(posedge sys_clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    @(negedge sys_clk_i);
    chk("sample after reset", 16'h0, {15'h0, sample_o});
    chk("chan after reset", 16'h0, {14'h0, chan_o});
    rd_chk(`ASC_OFF_MODE, 16'h0, "mode after reset");
    rd_chk(`ASC_OFF_MASK, 16'h0, "mask after reset");
    test_done();
  end
endmodule
`default_nettype wire
